// ===== superio_gpio_watchdog_config.sv
// Behaviour
// - direction bit one makes pin input, zero output; resets to all ones.
// - value bit writable while output; read-only while input; resets zero.
// - polarity bit one inverts value both ways between pin and register.
// - write-only index port decoded at 2Eh or 4Eh.
// - read/write data port at 2Fh or 4Fh reaches the indexed register.
// - two successive 87h writes to index port unlock configuration.
// - AAh written to index port locks configuration again.
// - index 07h holds logical device number selecting higher registers.
// - device 7 maps direction, value, polarity at F0, F1, F2.
// - device 8 maps the watchdog registers.
// - watchdog index 30h: 01h activates, 00h deactivates.
// - watchdog index F5h value 00h counts in seconds.
// - expired active watchdog resets cpu or raises interrupt.
`timescale 1ns/1ps
`include "cfg_gpio_consts.svh"

module superio_gpio_watchdog_config
	import cfg_gpio_pkg::*;
#(
	// one watchdog tick in clock cycles
	parameter int unsigned TICK_CYCLES = `CLK_HZ * `SEC_PER_TICK
)
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// host i/o cycle
	input  wire logic [7:0] io_addr,
	input  wire logic       io_wr,
	input  wire logic       io_rd,
	input  wire logic [7:0] io_wdata,
	output logic      [7:0] io_rdata,
	// general pins
	input  wire logic [7:0] general_pins_in,
	output logic      [7:0] general_pins_out,
	output logic      [7:0] general_pins_oe,
	// watchdog expiry
	input  wire logic       wdt_irq_mode,
	output logic            wdt_cpu_reset,
	output logic            wdt_irq
);

	typedef struct packed {
		lock_state_t lock;
		logic [7:0]  index;
		logic [7:0]  ldn;
		logic [7:0]  dir;
		logic [7:0]  val;
		logic [7:0]  pol;
		logic [7:0]  wdt_act;
		logic [7:0]  wdt_unit;
		logic [7:0]  wdt_count;
		logic [23:0] presc;
		logic [5:0]  minute;
		logic [7:0]  rst_cnt;
		logic [7:0]  rdata;
		logic [7:0]  pin_out;
		logic [7:0]  pin_oe;
		logic        cpu_rst;
		logic        irq;
		logic [7:0]  sync1;
		logic [7:0]  sync2;
		logic [7:0]  sync3;
		logic [7:0]  pin_stable;
	} state_t;

	state_t s_q;
	state_t s_d;

	localparam logic [23:0] TICK_CYC = 24'(TICK_CYCLES - 1);

	// address decode used for read and write paths
	function automatic logic is_index(input logic [7:0] a);
		is_index = (a == `ADDR_INDEX_A) || (a == `ADDR_INDEX_B);
	endfunction : is_index

	function automatic logic is_data(input logic [7:0] a);
		is_data = (a == `ADDR_DATA_A) || (a == `ADDR_DATA_B);
	endfunction : is_data

	// register read mux for the selected index
	function automatic logic [7:0] cfg_read(input state_t s, input logic [7:0] pins);
		cfg_read = `BYTE_ZERO;
		if (s.index == `IDX_LDN) begin
			cfg_read = s.ldn;
		end else if (s.ldn == `LDN_GPIO) begin
			case (s.index)
				`IDX_DIR: cfg_read = s.dir;
				// inputs show the (polarity corrected) pin, outputs the register
				`IDX_VAL: cfg_read = (s.dir & (pins ^ s.pol)) | (~s.dir & s.val);
				`IDX_POL: cfg_read = s.pol;
				default:  cfg_read = `BYTE_ZERO;
			endcase
		end else if (s.ldn == `LDN_WDT) begin
			case (s.index)
				`IDX_WDT_ACT:   cfg_read = s.wdt_act;
				`IDX_WDT_UNIT:  cfg_read = s.wdt_unit;
				`IDX_WDT_COUNT: cfg_read = s.wdt_count;
				default:        cfg_read = `BYTE_ZERO;
			endcase
		end
	endfunction : cfg_read

	logic tick_sec;
	logic count_tick;
	logic wr_idx;
	logic wr_dat;
	logic open_now;
	logic wr_wdt;
	logic wr_count;
	logic fire;

	// next-state logic
	always_comb begin
		s_d = s_q;
		wr_idx = io_wr && is_index(io_addr);
		wr_dat = io_wr && is_data(io_addr);
		open_now = (s_q.lock == LK_OPEN);

		// pin input synchroniser, change taken when stages 2 and 3 agree
		s_d.sync1 = general_pins_in;
		s_d.sync2 = s_q.sync1;
		s_d.sync3 = s_q.sync2;
		for (int i = 0; i < 8; i++) begin
			if (s_q.sync2[i] == s_q.sync3[i]) begin
				s_d.pin_stable[i] = s_q.sync3[i];
			end
		end

		// unlock / lock sequence on the index port
		if (wr_idx) begin
			case (s_q.lock)
				LK_LOCKED: s_d.lock = (io_wdata == `KEY_ENTER) ? LK_KEY1 : LK_LOCKED;
				LK_KEY1:   s_d.lock = (io_wdata == `KEY_ENTER) ? LK_OPEN : LK_LOCKED;
				LK_OPEN: begin
					if (io_wdata == `KEY_EXIT) begin
						s_d.lock = LK_LOCKED;
					end else begin
						s_d.index = io_wdata;
					end
				end
				default:   s_d.lock = LK_LOCKED;
			endcase
		end

		// data port writes, only while unlocked
		if (wr_dat && open_now) begin
			if (s_q.index == `IDX_LDN) begin
				s_d.ldn = io_wdata;
			end else if (s_q.ldn == `LDN_GPIO) begin
				case (s_q.index)
					`IDX_DIR: s_d.dir = io_wdata;
					`IDX_VAL: s_d.val = (s_q.val & s_q.dir) | (io_wdata & ~s_q.dir);
					`IDX_POL: s_d.pol = io_wdata;
					default:  s_d.val = s_q.val;
				endcase
			end else if (s_q.ldn == `LDN_WDT) begin
				case (s_q.index)
					`IDX_WDT_ACT:   s_d.wdt_act = io_wdata;
					`IDX_WDT_UNIT:  s_d.wdt_unit = io_wdata;
					`IDX_WDT_COUNT: s_d.wdt_count = io_wdata;
					default:        s_d.wdt_act = s_q.wdt_act;
				endcase
			end
		end

		// read data, registered; index port reads as zero
		if (io_rd && is_data(io_addr) && open_now) begin
			s_d.rdata = cfg_read(s_q, s_q.pin_stable);
		end else if (io_rd) begin
			s_d.rdata = `BYTE_ZERO;
		end

		// pin drive: outputs carry the value through polarity
		s_d.pin_out = s_q.val ^ s_q.pol;
		s_d.pin_oe = ~s_q.dir;

		// one-second prescaler and optional minute divider
		tick_sec = (s_q.presc == TICK_CYC);
		s_d.presc = tick_sec ? 24'h000000 : s_q.presc + 24'h000001;
		count_tick = 1'b0;
		if (tick_sec) begin
			if (s_q.wdt_unit == `WDT_UNIT_SEC) begin
				count_tick = 1'b1;
			end else if (s_q.minute == 6'(`MIN_PER_TICK - 1)) begin
				s_d.minute = 6'h00;
				count_tick = 1'b1;
			end else begin
				s_d.minute = s_q.minute + 6'h01;
			end
		end

		// watchdog count-down and expiry action
		wr_wdt = wr_dat && open_now && (s_q.ldn == `LDN_WDT);
		wr_count = wr_wdt && (s_q.index == `IDX_WDT_COUNT);
		fire = 1'b0;
		s_d.cpu_rst = (s_q.rst_cnt != `BYTE_ZERO);
		if (s_q.rst_cnt != `BYTE_ZERO) begin
			s_d.rst_cnt = s_q.rst_cnt - 8'h01;
		end
		// a reload in the tick cycle wins, else a serviced watchdog could still fire
		if (s_q.wdt_act[0] && count_tick && s_q.wdt_count != `BYTE_ZERO
				&& !wr_count) begin
			s_d.wdt_count = s_q.wdt_count - 8'h01;
			fire = (s_q.wdt_count == 8'h01);
		end
		// irq clears on reload or deactivation; a same-cycle expiry wins
		if (wr_wdt && (wr_count || s_q.index == `IDX_WDT_ACT)) begin
			s_d.irq = 1'b0;
		end
		if (fire && wdt_irq_mode) begin
			s_d.irq = 1'b1;
		end else if (fire) begin
			s_d.rst_cnt = `RESET_PULSE_CYC;
		end
	end

	// state register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.lock <= LK_LOCKED;
			s_q.dir <= `DIR_RESET;
			s_q.val <= `VAL_RESET;
			s_q.pol <= `POL_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flip-flops
	assign io_rdata = s_q.rdata;
	assign general_pins_out = s_q.pin_out;
	assign general_pins_oe = s_q.pin_oe;
	assign wdt_cpu_reset = s_q.cpu_rst;
	assign wdt_irq = s_q.irq;

	AST_UNLOCK_TWO_KEYS: assert property (@(posedge clock) disable iff (rst)
		(s_q.lock == LK_KEY1 && wr_idx && io_wdata == `KEY_ENTER)
			|=> s_q.lock == LK_OPEN)
		else $error("second key write did not unlock");

	AST_FIRST_KEY: assert property (@(posedge clock) disable iff (rst)
		(s_q.lock == LK_LOCKED && wr_idx && io_wdata == `KEY_ENTER) |=> s_q.lock == LK_KEY1)
		else $error("first key write not taken");

	AST_LOCKED_READ_ZERO: assert property (@(posedge clock) disable iff (rst)
		(!open_now && io_rd) |=> io_rdata == `BYTE_ZERO)
		else $error("locked port returned data");

	AST_OUTPUT_BIT_WRITE: assert property (@(posedge clock) disable iff (rst)
		(open_now && wr_dat && s_q.ldn == `LDN_GPIO && s_q.index == `IDX_VAL)
			|=> ((s_q.val ^ $past(io_wdata)) & ~$past(s_q.dir)) == 8'h00)
		else $error("value bit of an output pin not written");

	AST_RELOAD_WINS: assert property (@(posedge clock) disable iff (rst)
		wr_count |=> s_q.wdt_count == $past(io_wdata))
		else $error("watchdog reload lost to the count-down");

	AST_EXIT_LOCKS: assert property (@(posedge clock) disable iff (rst)
		(open_now && wr_idx && io_wdata == `KEY_EXIT) |=> s_q.lock == LK_LOCKED)
		else $error("exit code did not lock");

	AST_LOCKED_NO_WRITE: assert property (@(posedge clock) disable iff (rst)
		(!open_now && wr_dat) |=> $stable(s_q.dir) && $stable(s_q.ldn) && $stable(s_q.wdt_act))
		else $error("write changed registers while locked");

	AST_INPUT_BIT_HELD: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> ((s_q.val ^ $past(s_q.val)) & $past(s_q.dir)) == 8'h00)
		else $error("value bit of an input pin changed");

	AST_OE_FROM_DIR: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> general_pins_oe == ~$past(s_q.dir))
		else $error("output enable does not follow direction");

	AST_POLARITY_OUT: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> general_pins_out == ($past(s_q.val) ^ $past(s_q.pol)))
		else $error("pin output ignores polarity");

	AST_LDN_WRITE: assert property (@(posedge clock) disable iff (rst)
		(open_now && wr_dat && s_q.index == `IDX_LDN) |=> s_q.ldn == $past(io_wdata))
		else $error("logical device number not stored");

	AST_DIR_ONLY_LDN7: assert property (@(posedge clock) disable iff (rst)
		(s_q.ldn != `LDN_GPIO) |=> $stable(s_q.dir) && $stable(s_q.pol))
		else $error("pin register changed outside device 7");

	AST_WDT_ONLY_LDN8: assert property (@(posedge clock) disable iff (rst)
		(s_q.ldn != `LDN_WDT) |=> $stable(s_q.wdt_act) && $stable(s_q.wdt_unit))
		else $error("watchdog register changed outside device 8");

	AST_EXPIRY_ACTS: assert property (@(posedge clock) disable iff (rst)
		(s_q.wdt_act[0] && count_tick && s_q.wdt_count == 8'h01 && !wr_count)
			|-> ##[1:2] (wdt_irq || wdt_cpu_reset))
		else $error("expiry produced no reset or interrupt");

	AST_INACTIVE_HOLDS: assert property (@(posedge clock) disable iff (rst)
		(!s_q.wdt_act[0] && !wr_dat) |=> $stable(s_q.wdt_count))
		else $error("inactive watchdog counted");

endmodule : superio_gpio_watchdog_config

// ===== cfg_gpio_consts.svh
`ifndef CFG_GPIO_CONSTS_SVH
`define CFG_GPIO_CONSTS_SVH

// host i/o addresses
`define ADDR_INDEX_A      8'h2e
`define ADDR_INDEX_B      8'h4e
`define ADDR_DATA_A       8'h2f
`define ADDR_DATA_B       8'h4f
// lock codes
`define KEY_ENTER         8'h87
`define KEY_EXIT          8'haa
// configuration indexes
`define IDX_LDN           8'h07
`define IDX_WDT_ACT       8'h30
`define IDX_DIR           8'hf0
`define IDX_VAL           8'hf1
`define IDX_POL           8'hf2
`define IDX_WDT_UNIT      8'hf5
`define IDX_WDT_COUNT     8'hf6
// logical devices
`define LDN_GPIO          8'h07
`define LDN_WDT           8'h08
// reset values and register codes
`define DIR_RESET         8'hff
`define VAL_RESET         8'h00
`define POL_RESET         8'h00
`define BYTE_ZERO         8'h00
`define WDT_ON            8'h01
`define WDT_UNIT_SEC      8'h00
// timing: clock 10 MHz
`define CLK_HZ            10000000
`define SEC_PER_TICK      1
`define MIN_PER_TICK      60
`define RESET_PULSE_CYC   8'h10

`endif

// ===== cfg_gpio_pkg.sv
package cfg_gpio_pkg;

	typedef enum logic [1:0] {
		LK_LOCKED = 2'b00,
		LK_KEY1   = 2'b01,
		LK_OPEN   = 2'b11
	} lock_state_t;

endpackage : cfg_gpio_pkg

// ===== host_io_model.sv
`timescale 1ns/1ps
`include "cfg_gpio_consts.svh"

module host_io_model (
	// clock
	input  wire logic       clock,
	// host i/o cycle
	output logic      [7:0] io_addr,
	output logic            io_wr,
	output logic            io_rd,
	output logic      [7:0] io_wdata,
	input  wire logic [7:0] io_rdata
);
	// idle bus at start
	initial begin
		io_addr  = 8'h00;
		io_wr    = 1'b0;
		io_rd    = 1'b0;
		io_wdata = 8'h00;
	end
	// one write pulse, then an idle cycle with scrambled address and data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		io_addr  = a;
		io_wdata = d;
		io_wr    = 1'b1;
		@(posedge clock);
		#1;
		io_wr    = 1'b0;
		io_addr  = ~a;
		io_wdata = ~d;
		@(posedge clock);
		#1;
	endtask : wr
	// one read pulse; data settled just after the following edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		io_addr = a;
		io_rd   = 1'b1;
		@(posedge clock);
		#1;
		io_rd   = 1'b0;
		io_addr = ~a;
		@(posedge clock);
		#1;
		d = io_rdata;
	endtask : rd
	// two key writes in succession open the port
	task automatic unlock(input logic [7:0] ip);
		wr(ip, `KEY_ENTER);
		wr(ip, `KEY_ENTER);
	endtask : unlock
	// exit code closes the port
	task automatic lock(input logic [7:0] ip);
		wr(ip, `KEY_EXIT);
	endtask : lock
endmodule : host_io_model

// ===== tb.sv
`timescale 1ns/1ps
`include "cfg_gpio_consts.svh"

module tb
	import cfg_gpio_pkg::*;
;
	typedef struct packed {
		logic       alt;
		logic [7:0] widx, wdata, ridx, rexp, oe, out;
	} row_t;

	logic       clock, rst, io_wr, io_rd, irq_mode, cpu_reset, irq;
	logic [7:0] io_addr, io_wdata, io_rdata, pins_in, pins_out, pins_oe, d;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         pulse_len;
	// short watchdog tick so an expiry fits in the run
	localparam int TICK_LEN = 40;
	// gpio walk with pins held at 3c: write, read back, pins
	row_t rows [8] = '{
		'{1'b0, 8'hf0, 8'h00, 8'hf0, 8'h00, 8'hff, 8'h00},
		'{1'b1, 8'hf1, 8'ha5, 8'hf1, 8'ha5, 8'hff, 8'ha5},
		'{1'b0, 8'hf2, 8'h0f, 8'hf2, 8'h0f, 8'hff, 8'haa},
		'{1'b1, 8'hf0, 8'hf0, 8'hf1, 8'h35, 8'h0f, 8'haa},
		'{1'b0, 8'hf1, 8'h00, 8'hf1, 8'h30, 8'h0f, 8'haf},
		'{1'b0, 8'hf2, 8'hff, 8'hf1, 8'hc0, 8'h0f, 8'h5f},
		'{1'b1, 8'h07, 8'h08, 8'hf0, 8'h00, 8'h0f, 8'h5f},
		'{1'b0, 8'h07, 8'h07, 8'hf0, 8'hf0, 8'h0f, 8'h5f}};

	superio_gpio_watchdog_config #(.TICK_CYCLES(TICK_LEN)) DUT (.clock, .rst, .io_addr,
		.io_wr, .io_rd, .io_wdata,
		.io_rdata, .general_pins_in(pins_in), .general_pins_out(pins_out),
		.general_pins_oe(pins_oe), .wdt_irq_mode(irq_mode), .wdt_cpu_reset(cpu_reset),
		.wdt_irq(irq));
	host_io_model host (.clock, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata);

	// 10 MHz clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wreg(input logic alt, input logic [7:0] i, input logic [7:0] v);
		host.wr(alt ? `ADDR_INDEX_B : `ADDR_INDEX_A, i);
		host.wr(alt ? `ADDR_DATA_B : `ADDR_DATA_A, v);
	endtask : wreg

	task automatic rreg(input logic alt, input logic [7:0] i, output logic [7:0] v);
		host.wr(alt ? `ADDR_INDEX_B : `ADDR_INDEX_A, i);
		host.rd(alt ? `ADDR_DATA_B : `ADDR_DATA_A, v);
	endtask : rreg

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// hang guard, far beyond the four hundred or so cycles the tests need
	initial begin
		#(20000 * 100);
		n_mismatch++;
		print_verdict();
	end

	// main sequence
	initial begin
		rst      = 1'b1;
		pins_in  = 8'h3c;
		irq_mode = 1'b0;
		repeat (5) @(posedge clock);
		#1 rst = 1'b0;
		chk(pins_oe, 8'h00);
		chk(pins_out, `VAL_RESET);
		host.unlock(`ADDR_INDEX_A);
		wreg(1'b0, `IDX_LDN, `LDN_GPIO);
		rreg(1'b0, `IDX_DIR, d);
		chk(d, `DIR_RESET);
		rreg(1'b0, `IDX_VAL, d);
		chk(d, 8'h3c);
		rreg(1'b0, `IDX_POL, d);
		chk(d, `POL_RESET);
		$display("test reset done");
		foreach (rows[k]) begin
			wreg(rows[k].alt, rows[k].widx, rows[k].wdata);
			rreg(rows[k].alt, rows[k].ridx, d);
			chk(d, rows[k].rexp);
			chk(pins_oe, rows[k].oe);
			chk(pins_out, rows[k].out);
		end
		$display("test table done");
		// locked port ignores data writes and reads zero
		host.lock(`ADDR_INDEX_A);
		wreg(1'b0, `IDX_DIR, 8'h00);
		rreg(1'b0, `IDX_DIR, d);
		chk(d, `BYTE_ZERO);
		host.unlock(`ADDR_INDEX_B);
		rreg(1'b0, `IDX_DIR, d);
		chk(d, 8'hf0);
		chk(pins_oe, 8'h0f);
		$display("test lock done");
		// interrupted key sequence stays locked
		host.lock(`ADDR_INDEX_A);
		host.wr(`ADDR_INDEX_A, `KEY_ENTER);
		host.wr(`ADDR_INDEX_A, 8'h55);
		host.wr(`ADDR_INDEX_A, `KEY_ENTER);
		rreg(1'b0, `IDX_DIR, d);
		chk(d, `BYTE_ZERO);
		host.unlock(`ADDR_INDEX_A);
		rreg(1'b0, `IDX_DIR, d);
		chk(d, 8'hf0);
		$display("test key done");
		// watchdog registers, no expiry with a zero count
		wreg(1'b0, `IDX_LDN, `LDN_WDT);
		wreg(1'b0, `IDX_WDT_ACT, `WDT_ON);
		rreg(1'b0, `IDX_WDT_ACT, d);
		chk(d, `WDT_ON);
		wreg(1'b0, `IDX_WDT_UNIT, `WDT_UNIT_SEC);
		rreg(1'b0, `IDX_WDT_UNIT, d);
		chk(d, `WDT_UNIT_SEC);
		chk({6'h00, cpu_reset, irq}, 8'h00);
		wreg(1'b0, `IDX_WDT_ACT, `BYTE_ZERO);
		rreg(1'b0, `IDX_WDT_ACT, d);
		chk(d, `BYTE_ZERO);
		$display("test watchdog done");
		// short count expires: cpu reset pulse first, then interrupt mode
		wreg(1'b0, `IDX_WDT_COUNT, 8'h02);
		wreg(1'b0, `IDX_WDT_ACT, `WDT_ON);
		pulse_len = 0;
		repeat (4 * TICK_LEN) begin
			@(posedge clock);
			#1;
			if (cpu_reset === 1'b1)
				pulse_len++;
		end
		chk(8'(pulse_len), `RESET_PULSE_CYC);
		chk({6'h00, cpu_reset, irq}, 8'h00);
		rreg(1'b0, `IDX_WDT_COUNT, d);
		chk(d, `BYTE_ZERO);
		irq_mode = 1'b1;
		wreg(1'b0, `IDX_WDT_COUNT, 8'h01);
		repeat (2 * TICK_LEN) @(posedge clock);
		#1;
		chk({6'h00, cpu_reset, irq}, 8'h01);
		wreg(1'b0, `IDX_WDT_ACT, `BYTE_ZERO);
		chk({6'h00, cpu_reset, irq}, 8'h00);
		$display("test expiry done");
		// reset in mid-run: locked again, registers back to defaults
		@(posedge clock);
		#1 rst = 1'b1;
		@(posedge clock);
		#1 rst = 1'b0;
		chk(pins_oe, 8'h00);
		chk(pins_out, `VAL_RESET);
		chk({6'h00, cpu_reset, irq}, 8'h00);
		rreg(1'b0, `IDX_LDN, d);
		chk(d, `BYTE_ZERO);
		host.unlock(`ADDR_INDEX_A);
		wreg(1'b0, `IDX_LDN, `LDN_GPIO);
		rreg(1'b1, `IDX_DIR, d);
		chk(d, `DIR_RESET);
		rreg(1'b1, `IDX_POL, d);
		chk(d, `POL_RESET);
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule : tb
